// ===== inc/pfc_defs.vh
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// register byte offsets inside the block window
`define PFC_REG_KEY 8'h00
`define PFC_REG_43_40 8'h28
`define PFC_REG_47_44 8'h2C
`define PFC_REG_49_48 8'h30

// default unlock key value (arbitrary)
`define PFC_KEY_DEFAULT 32'h00000073

// field positions inside one 8-bit pad lane
`define PFC_LANE_W 8
`define PFC_FSEL_HI 4
`define PFC_FSEL_LO 3
`define PFC_STRNG_BIT 2
`define PFC_INPEN_BIT 1
`define PFC_PULL_BIT 0

// lane reset: function select 3 (gpio), all other bits 0
`define PFC_LANE_RESET 5'h18

// function select codes
`define PFC_SEL0 2'h0
`define PFC_SEL1 2'h1
`define PFC_SEL2 2'h2
`define PFC_SEL_GPIO 2'h3

// ahb encodings
`define PFC_HSIZE_WORD 3'h2
`define PFC_HRESP_OKAY 1'h0

`endif

// ===== rtl/pfc_pad_lane.v
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.vh"

module pfc_pad_lane (
  input wire clock,
  input wire nrst,
  input wire wrEn,
  input wire [4:0] wrData,
  output wire [7:0] laneOut
);

  reg [4:0] lane_r;

  // lane storage; reserved bits 7:5 are never stored
  always @(posedge clock) begin
    if (!nrst) begin
      lane_r <= `PFC_LANE_RESET;
    end else if (wrEn) begin
      lane_r <= wrData;
    end
  end

  assign laneOut = {3'h0, lane_r};

endmodule

`default_nettype wire

// ===== rtl/pfc_ahb_slave.v
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.vh"

module pfc_ahb_slave (
  input wire clock,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  output wire [7:0] rdAddr,
  input wire [31:0] rdData,
  output wire wrStrobe,
  output wire [7:0] wrAddr,
  output wire [31:0] wrData
);

  reg wrPend_r;
  reg [7:0] wrAddr_r;
  reg [31:0] hrdata_r;
  wire accept;

  // address phase taken only for a selected nonseq/seq transfer
  assign accept = hsel & htrans[1] & hready;
  assign rdAddr = haddr[7:0];

  // write is remembered for its data phase; only whole words are honoured
  always @(posedge clock) begin
    if (!nrst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else if (hready) begin
      wrPend_r <= accept & hwrite & (hsize == `PFC_HSIZE_WORD);
      wrAddr_r <= haddr[7:0];
    end
  end

  // read data sampled at the address phase so it stands in the data phase
  always @(posedge clock) begin
    if (!nrst) begin
      hrdata_r <= 32'h00000000;
    end else if (accept & ~hwrite) begin
      hrdata_r <= rdData;
    end
  end

  // zero wait state, always okay: the register file never stalls
  assign hreadyout = 1'b1;
  assign hresp = `PFC_HRESP_OKAY;
  assign hrdata = hrdata_r;
  assign wrStrobe = wrPend_r;
  assign wrAddr = wrAddr_r;
  assign wrData = hwdata;

endmodule

`default_nettype wire

// ===== rtl/pfc_pad_config.v
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_defs.vh"

// Function
// - pad 41 select: 0 adc trigger 4, 1 off, 2 trace out, 3 gpio; reset 3
// - pad 40 select: 0 adc trigger 3, 1 uart receive, 2 off, 3 gpio
// - pad 47 select: 0 off, 1 master0 chip select 5, 2 timer b2, 3 gpio
// - pad 46 select: 0 off, 1 master0 chip select 4, 2 timer a2, 3 gpio
// - pad 45 select: 0 off, 1 master0 chip select 3, 2 timer b1, 3 gpio
// - pad 44 select: 0 adc trigger 7, 1 chip select 2, 2 timer a1, 3 gpio
// - pad 49 select: 0 off, 1 master0 chip select 7, 2 timer b3, 3 gpio
// - pad 48 select: 0 off, 1 master0 chip select 6, 2 timer a3, 3 gpio
// - each pad has a drive strength bit, 1 high, reset 0
// - each pad has an input enable bit, 1 enabled, reset 0
// - each pad has a pull-up enable bit, 1 enabled, reset 0
// - pad register writes only take effect while the key has unlocked them
// - pads 47..44 packed in 8-bit lanes, selects at 28:27, 20:19, 12:11, 4:3
// - last register holds pads 49, 48 only; bits 31:13 and reserved read zero

module pfc_pad_config #(
  parameter [31:0] UNLOCK_KEY = `PFC_KEY_DEFAULT
) (
  input wire clock,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [9:0] padIn,
  output wire [9:0] padOut,
  output wire [9:0] padOutEn,
  output wire [9:0] padDriveHigh,
  output wire [9:0] padInputEn,
  output wire [9:0] padPullupEn,
  output wire adcTrigger3Input,
  output wire adcTrigger4Input,
  output wire adcTrigger5Input,
  output wire adcTrigger6Input,
  output wire adcTrigger7Input,
  output wire uartReceiveInput,
  input wire debugTraceOutput,
  input wire [7:0] master0ChipSelectN,
  input wire [7:0] timerPinOut,
  input wire [7:0] timerPinOutEn,
  output wire [7:0] timerPinIn,
  input wire [9:0] gpioOut,
  input wire [9:0] gpioOutEn,
  output wire [9:0] gpioIn,
  output wire keyUnlocked
);

  wire [7:0] rdAddr;
  wire wrStrobe;
  wire [7:0] wrAddr;
  wire [31:0] wrData;
  reg [31:0] rdData;
  wire [79:0] laneBits;
  wire [2:0] regWr;
  wire [9:0] padInQ;
  wire [1:0] fsel [0:9];
  reg keyUnlocked_r;

  reg [9:0] padOut_r;
  reg [9:0] padOutEn_r;
  reg [4:0] adcTrig_r;
  reg uart_receive_input_r;
  reg [7:0] timerIn_r;
  reg [9:0] gpioIn_r;

  reg [9:0] padOut_nxt;
  reg [9:0] padOutEn_nxt;
  reg [4:0] adcTrig_nxt;
  reg uart_receive_input_nxt;
  reg [7:0] timerIn_nxt;
  reg [9:0] gpioIn_nxt;

  // bus front end, zero wait state
  pfc_ahb_slave u_bus (
    .clock(clock),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData)
  );

  // key: writing the key value unlocks, any other value locks again
  always @(posedge clock) begin
    if (!nrst) begin
      keyUnlocked_r <= 1'b0;
    end else if (wrStrobe && (wrAddr == `PFC_REG_KEY)) begin
      keyUnlocked_r <= (wrData == UNLOCK_KEY);
    end
  end

  assign keyUnlocked = keyUnlocked_r;

  // pad register writes gated by the key; a locked write just vanishes
  assign regWr[0] = wrStrobe & keyUnlocked_r & (wrAddr == `PFC_REG_43_40);
  assign regWr[1] = wrStrobe & keyUnlocked_r & (wrAddr == `PFC_REG_47_44);
  assign regWr[2] = wrStrobe & keyUnlocked_r & (wrAddr == `PFC_REG_49_48);

  // one lane per pad: pad 40+g sits in register g/4, byte lane g%4
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gLane
      pfc_pad_lane u_lane (
        .clock(clock),
        .nrst(nrst),
        .wrEn(regWr[g / 4]),
        .wrData(wrData[(g % 4) * `PFC_LANE_W +: 5]),
        .laneOut(laneBits[g * `PFC_LANE_W +: `PFC_LANE_W])
      );
      assign fsel[g] = laneBits[g * `PFC_LANE_W + `PFC_FSEL_LO +: 2];
      assign padDriveHigh[g] = laneBits[g * `PFC_LANE_W + `PFC_STRNG_BIT];
      assign padInputEn[g] = laneBits[g * `PFC_LANE_W + `PFC_INPEN_BIT];
      assign padPullupEn[g] = laneBits[g * `PFC_LANE_W + `PFC_PULL_BIT];
    end
  endgenerate

  // read mux; lanes carry zero in their reserved bits, unmapped reads zero
  always @* begin
    case (rdAddr)
      `PFC_REG_KEY: rdData = {31'h00000000, keyUnlocked_r};
      `PFC_REG_43_40: rdData = laneBits[31:0];
      `PFC_REG_47_44: rdData = laneBits[63:32];
      `PFC_REG_49_48: rdData = {16'h0000, laneBits[79:64]};
      default: rdData = 32'h00000000;
    endcase
  end

  // a pad whose input path is off presents a steady low inward
  assign padInQ = padIn & padInputEn;

  // function routing; unrouted peripheral inputs rest low, uart rx idles high
  always @* begin
    padOut_nxt = 10'h000;
    padOutEn_nxt = 10'h000;
    adcTrig_nxt = 5'h00;
    uart_receive_input_nxt = 1'b1;
    timerIn_nxt = 8'h00;
    gpioIn_nxt = 10'h000;

    // pad 40
    case (fsel[0])
      `PFC_SEL0: adcTrig_nxt[0] = padInQ[0];
      `PFC_SEL1: uart_receive_input_nxt = padInQ[0];
      `PFC_SEL2: padOutEn_nxt[0] = 1'b0;
      default: begin
        padOut_nxt[0] = gpioOut[0];
        padOutEn_nxt[0] = gpioOutEn[0];
        gpioIn_nxt[0] = padInQ[0];
      end
    endcase

    // pad 41
    case (fsel[1])
      `PFC_SEL0: adcTrig_nxt[1] = padInQ[1];
      `PFC_SEL1: padOutEn_nxt[1] = 1'b0;
      `PFC_SEL2: begin
        padOut_nxt[1] = debugTraceOutput;
        padOutEn_nxt[1] = 1'b1;
      end
      default: begin
        padOut_nxt[1] = gpioOut[1];
        padOutEn_nxt[1] = gpioOutEn[1];
        gpioIn_nxt[1] = padInQ[1];
      end
    endcase

    // pad 42
    case (fsel[2])
      `PFC_SEL0: adcTrig_nxt[2] = padInQ[2];
      `PFC_SEL1: begin
        padOut_nxt[2] = master0ChipSelectN[0];
        padOutEn_nxt[2] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[2] = timerPinOut[0];
        padOutEn_nxt[2] = timerPinOutEn[0];
        timerIn_nxt[0] = padInQ[2];
      end
      default: begin
        padOut_nxt[2] = gpioOut[2];
        padOutEn_nxt[2] = gpioOutEn[2];
        gpioIn_nxt[2] = padInQ[2];
      end
    endcase

    // pad 43
    case (fsel[3])
      `PFC_SEL0: adcTrig_nxt[3] = padInQ[3];
      `PFC_SEL1: begin
        padOut_nxt[3] = master0ChipSelectN[1];
        padOutEn_nxt[3] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[3] = timerPinOut[1];
        padOutEn_nxt[3] = timerPinOutEn[1];
        timerIn_nxt[1] = padInQ[3];
      end
      default: begin
        padOut_nxt[3] = gpioOut[3];
        padOutEn_nxt[3] = gpioOutEn[3];
        gpioIn_nxt[3] = padInQ[3];
      end
    endcase

    // pad 44
    case (fsel[4])
      `PFC_SEL0: adcTrig_nxt[4] = padInQ[4];
      `PFC_SEL1: begin
        padOut_nxt[4] = master0ChipSelectN[2];
        padOutEn_nxt[4] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[4] = timerPinOut[2];
        padOutEn_nxt[4] = timerPinOutEn[2];
        timerIn_nxt[2] = padInQ[4];
      end
      default: begin
        padOut_nxt[4] = gpioOut[4];
        padOutEn_nxt[4] = gpioOutEn[4];
        gpioIn_nxt[4] = padInQ[4];
      end
    endcase

    // pads 45 to 49 share one pattern: off, chip select, timer pin, gpio
    case (fsel[5])
      `PFC_SEL0: padOutEn_nxt[5] = 1'b0;
      `PFC_SEL1: begin
        padOut_nxt[5] = master0ChipSelectN[3];
        padOutEn_nxt[5] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[5] = timerPinOut[3];
        padOutEn_nxt[5] = timerPinOutEn[3];
        timerIn_nxt[3] = padInQ[5];
      end
      default: begin
        padOut_nxt[5] = gpioOut[5];
        padOutEn_nxt[5] = gpioOutEn[5];
        gpioIn_nxt[5] = padInQ[5];
      end
    endcase

    case (fsel[6])
      `PFC_SEL0: padOutEn_nxt[6] = 1'b0;
      `PFC_SEL1: begin
        padOut_nxt[6] = master0ChipSelectN[4];
        padOutEn_nxt[6] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[6] = timerPinOut[4];
        padOutEn_nxt[6] = timerPinOutEn[4];
        timerIn_nxt[4] = padInQ[6];
      end
      default: begin
        padOut_nxt[6] = gpioOut[6];
        padOutEn_nxt[6] = gpioOutEn[6];
        gpioIn_nxt[6] = padInQ[6];
      end
    endcase

    case (fsel[7])
      `PFC_SEL0: padOutEn_nxt[7] = 1'b0;
      `PFC_SEL1: begin
        padOut_nxt[7] = master0ChipSelectN[5];
        padOutEn_nxt[7] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[7] = timerPinOut[5];
        padOutEn_nxt[7] = timerPinOutEn[5];
        timerIn_nxt[5] = padInQ[7];
      end
      default: begin
        padOut_nxt[7] = gpioOut[7];
        padOutEn_nxt[7] = gpioOutEn[7];
        gpioIn_nxt[7] = padInQ[7];
      end
    endcase

    case (fsel[8])
      `PFC_SEL0: padOutEn_nxt[8] = 1'b0;
      `PFC_SEL1: begin
        padOut_nxt[8] = master0ChipSelectN[6];
        padOutEn_nxt[8] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[8] = timerPinOut[6];
        padOutEn_nxt[8] = timerPinOutEn[6];
        timerIn_nxt[6] = padInQ[8];
      end
      default: begin
        padOut_nxt[8] = gpioOut[8];
        padOutEn_nxt[8] = gpioOutEn[8];
        gpioIn_nxt[8] = padInQ[8];
      end
    endcase

    case (fsel[9])
      `PFC_SEL0: padOutEn_nxt[9] = 1'b0;
      `PFC_SEL1: begin
        padOut_nxt[9] = master0ChipSelectN[7];
        padOutEn_nxt[9] = 1'b1;
      end
      `PFC_SEL2: begin
        padOut_nxt[9] = timerPinOut[7];
        padOutEn_nxt[9] = timerPinOutEn[7];
        timerIn_nxt[7] = padInQ[9];
      end
      default: begin
        padOut_nxt[9] = gpioOut[9];
        padOutEn_nxt[9] = gpioOutEn[9];
        gpioIn_nxt[9] = padInQ[9];
      end
    endcase
  end

  // routed signals are retimed: one cycle of latency buys glitch-free
  // outputs when a select changes under a live peripheral
  always @(posedge clock) begin
    if (!nrst) begin
      padOut_r <= 10'h000;
      padOutEn_r <= 10'h000;
      adcTrig_r <= 5'h00;
      uart_receive_input_r <= 1'b1;
      timerIn_r <= 8'h00;
      gpioIn_r <= 10'h000;
    end else begin
      padOut_r <= padOut_nxt;
      padOutEn_r <= padOutEn_nxt;
      adcTrig_r <= adcTrig_nxt;
      uart_receive_input_r <= uart_receive_input_nxt;
      timerIn_r <= timerIn_nxt;
      gpioIn_r <= gpioIn_nxt;
    end
  end

  assign padOut = padOut_r;
  assign padOutEn = padOutEn_r;
  assign adcTrigger3Input = adcTrig_r[0];
  assign adcTrigger4Input = adcTrig_r[1];
  assign adcTrigger5Input = adcTrig_r[2];
  assign adcTrigger6Input = adcTrig_r[3];
  assign adcTrigger7Input = adcTrig_r[4];
  assign uartReceiveInput = uart_receive_input_r;
  assign timerPinIn = timerIn_r;
  assign gpioIn = gpioIn_r;

endmodule

`default_nettype wire

// ===== tb/pfc_pad_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_pad_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [9:0] padIn,
  input wire logic [9:0] padOut,
  input wire logic [9:0] padOutEn,
  input wire logic [9:0] padDriveHigh,
  input wire logic [9:0] padInputEn,
  input wire logic [9:0] padPullupEn,
  input wire logic adcTrigger7Input,
  input wire logic debugTraceOutput,
  input wire logic [9:0] gpioOutEn,
  input wire logic [9:0] gpioIn,
  input wire logic [7:0] timerPinIn,
  input wire logic keyUnlocked
);
  logic rdPend_r;
  logic wrPend_r;
  logic [7:0] offs_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // track data phases, since read data and key writes land there, not in the address phase
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdPend_r <= 1'b0;
      wrPend_r <= 1'b0;
      offs_r <= 8'h00;
    end else if (hready) begin
      rdPend_r <= hsel && htrans[1] && !hwrite;
      wrPend_r <= hsel && htrans[1] && hwrite;
      offs_r <= haddr[7:0];
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with error");
  a_reset_clear: assert property ($rose(nrst) |-> {padDriveHigh, padInputEn, padPullupEn} == 30'h0)
    else $error("pad control bits not clear after reset");
  a_locked_frozen: assert property (!keyUnlocked |=> $stable({padDriveHigh, padInputEn, padPullupEn}))
    else $error("pad controls changed while locked");
  a_key_cause: assert property ($past(nrst) && $changed(keyUnlocked) |-> $past(wrPend_r && offs_r == 8'h00))
    else $error("lock state moved without a key write");
  a_read_rsvd: assert property (rdPend_r |-> (hrdata & 32'hE0E0E0E0) == 32'h0)
    else $error("reserved lane bits read nonzero");
  a_read_high: assert property (rdPend_r && offs_r == 8'h30 |-> hrdata[31:13] == 19'h0)
    else $error("upper half of last pad register read nonzero");
  a_gpio_gate: assert property (1'b1 |=> (gpioIn & ~$past(padInputEn)) == 10'h0)
    else $error("gpio input seen with input path off");
  a_timer_gate: assert property (1'b1 |=> (timerPinIn & ~$past(padInputEn[9:2])) == 8'h0)
    else $error("timer input seen with input path off");
  a_adc7_cause: assert property (adcTrigger7Input |-> $past(padIn[4] && padInputEn[4]))
    else $error("trigger 7 high without an enabled high pad");
  a_trace_src: assert property (padOutEn[1] && !$past(gpioOutEn[1]) |-> padOut[1] == $past(debugTraceOutput))
    else $error("pad 41 drives something other than trace");
  c_key_open: cover property ($rose(keyUnlocked));
  c_pad_write: cover property (wrPend_r && offs_r == 8'h2C && keyUnlocked);
  c_trace_on: cover property (padOutEn[1] && !$past(gpioOutEn[1]));
endmodule
bind pfc_pad_config pfc_pad_monitor u_mon (.clock(clock), .nrst(nrst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .padIn(padIn), .padOut(padOut), .padOutEn(padOutEn),
  .padDriveHigh(padDriveHigh), .padInputEn(padInputEn), .padPullupEn(padPullupEn),
  .adcTrigger7Input(adcTrigger7Input), .debugTraceOutput(debugTraceOutput),
  .gpioOutEn(gpioOutEn), .gpioIn(gpioIn), .timerPinIn(timerPinIn),
  .keyUnlocked(keyUnlocked));
`default_nettype wire

// ===== tb/pfc_pad_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_pad_far_side (
  input wire logic [9:0] padOut,
  input wire logic [9:0] padOutEn,
  input wire logic [9:0] padPullupEn,
  input wire logic [9:0] extLevel,
  output logic [9:0] padIn
);
  // a driven pad shows its own level; a released one goes to the pull-up or the outside level
  assign padIn = (padOutEn & padOut) | (~padOutEn & (padPullupEn | extLevel));
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] KEY = 32'h00000073; // arbitrary unlock value
  logic clock, nrst, hsel, hwrite, trc;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] csN, tmrO, tmrOe;
  logic [9:0] gOut, gOe, ext;
  wire hrdy, uart_receive_input;
  wire [31:0] hrdata;
  wire [9:0] padIn, padOut, padOutEn, dh, ie, pu, gIn;
  wire [7:0] tmrIn;
  wire [4:0] adcV;
  int failures, checks_done;

  pfc_pad_config #(.UNLOCK_KEY(KEY)) dut (.clock(clock), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata(hrdata), .padIn(padIn),
    .padOut(padOut), .padOutEn(padOutEn), .padDriveHigh(dh), .padInputEn(ie),
    .padPullupEn(pu), .adcTrigger3Input(adcV[0]), .adcTrigger4Input(adcV[1]),
    .adcTrigger5Input(adcV[2]), .adcTrigger6Input(adcV[3]), .adcTrigger7Input(adcV[4]),
    .uartReceiveInput(uart_receive_input), .debugTraceOutput(trc), .master0ChipSelectN(csN),
    .timerPinOut(tmrO), .timerPinOutEn(tmrOe), .timerPinIn(tmrIn), .gpioOut(gOut),
    .gpioOutEn(gOe), .gpioIn(gIn), .keyUnlocked());
  pfc_pad_far_side far (.padOut(padOut), .padOutEn(padOutEn), .padPullupEn(pu),
    .extLevel(ext), .padIn(padIn));

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; waits are bounded since a stuck hready must not hang the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hrdy !== 1'b1 && ++n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hrdy !== 1'b1 && ++n < 20);
    q = hrdata;
    if (n >= 20) begin
      failures++;
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("readback", q, exp);
  endtask

  // select one function on pad 40+i, then drive both levels through it
  task automatic dec(input int i, input logic [1:0] s);
    logic [31:0] w;
    int t, x;
    logic v, oe, got;
    w = 32'h18181818;
    w[8 * (i % 4) +: 8] = {3'h0, s, 3'h6};
    t = 6;
    x = (i < 2 || s == 2'h0) ? i + 3 : i - 2;
    if (s != 2'h3) begin
      if (i == 0) t = (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : 0;
      else if (i == 1) t = (s == 2'h0) ? 1 : (s == 2'h1) ? 0 : 3;
      else if (s == 2'h0) t = (i < 5) ? 1 : 0;
      else t = s + 3;
    end
    xfer(1'b1, 8'(40 + 4 * (i / 4)), w);
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      trc <= v;
      csN <= {8{v}};
      tmrO <= {8{v}};
      tmrOe <= 8'hFF;
      gOut <= {10{v}};
      // gpio enables stay off unless gpio is under test, so a trace drive is seen by itself
      gOe <= (t == 6) ? 10'h3FF : 10'h000;
      ext <= {10{v}};
      // at this edge the sampled outputs are those settled after the previous one
      repeat (3) @(posedge clock);
      oe = (t >= 3);
      chk("padOutEn", padOutEn[i], oe);
      if (oe) chk("padOut", padOut[i], v);
      got = (t == 1) ? adcV[x - 3] : (t == 2) ? uart_receive_input : (t == 5) ? tmrIn[x] : (t == 6) ? gIn[i] : v;
      chk("routed input", got, v);
      chk("gpioIn", gIn[i], (t == 6) & v);
    end
  endtask

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trc = 1'b0;
    csN = 8'hFF;
    tmrO = 8'h00;
    tmrOe = 8'h00;
    gOut = 10'h000;
    gOe = 10'h000;
    ext = 10'h000;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd(8'h2C, 32'h18181818);
    rd(8'h30, 32'h00001818);
    rd(8'h28, 32'h18181818);
    rd(8'h00, 32'h0);
    chk("pad controls", {dh, ie, pu}, 32'h0);
    $display("test reset done");
    xfer(1'b1, 8'h2C, 32'hFFFFFFFF);
    xfer(1'b1, 8'h00, KEY ^ 32'h1);
    xfer(1'b1, 8'h30, 32'h0);
    rd(8'h2C, 32'h18181818);
    rd(8'h30, 32'h00001818);
    $display("test locked done");
    xfer(1'b1, 8'h00, KEY);
    rd(8'h00, 32'h1);
    // a halfword write is dropped even while unlocked; unmapped space reads zero
    hsize <= 3'h1;
    xfer(1'b1, 8'h2C, 32'h00000000);
    hsize <= 3'h2;
    rd(8'h2C, 32'h18181818);
    rd(8'h34, 32'h0);
    xfer(1'b1, 8'h2C, 32'hFFFFFFFF);
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    rd(8'h2C, 32'h1F1F1F1F);
    rd(8'h30, 32'h00001F1F);
    @(posedge clock);
    chk("pad controls", {dh, ie, pu}, {10'h3F0, 10'h3F0, 10'h3F0});
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h2C, 32'h18191A1C);
    // one more edge so the write that landed at the last edge is visible
    @(posedge clock);
    chk("pad controls", {dh, ie, pu}, {10'h010, 10'h020, 10'h040});
    $display("test fields done");
    for (int i = 0; i < 10; i++) begin
      for (int s = 0; s < 4; s++) begin
        dec(i, 2'(s));
      end
    end
    $display("test decode done");
    final_report();
  end
endmodule
`default_nettype wire
